/* hw/lmap_lower_page.sv */
// Lower page of the module management map with upper pages 00, 02 and 03.
// Assumes one core clock, power-on reset on rst_in and a host on the 2-wire bus.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Lower page of 128 bytes, 0 to 127, reachable whatever page is selected.
// R2: Byte 127 selects which upper page answers addresses 128 to 255.
// R3: Upper pages 00, 02, 03 exist; page 01 and others read zero.
// R4: Byte 0 returns the identifier, same value as upper page 00 byte 128.
// R5: Host may write control bytes 86-97 and mask bytes 100-106.
// R6: Bytes 0 to 85 ignore writes.
// R7: Status byte 2 bit 2 reads one, meaning paged upper memory.
// R8: Status byte 2 bit 1 mirrors the interrupt pin level.
// R9: Status byte 2 bit 0 high from power-up until monitors are valid.
// R10: Once low, the monitor-pending bit stays low until power is removed.
// R11: Flag bytes 3 to 21 read zero normally, ones on fault conditions.
// R12: Byte 3 bits 0-3 latch receive signal loss for channels 1-4.
// R13: Byte 4 bits 0-3 latch transmit fault for channels 1-4.
// R14: Reserved bytes and bits read zero; writes to them are ignored.
// R15: Flag set and interrupt asserted within 200 ms of the condition.
// R16: Reading a flag clears it; interrupt releases within 500 us after. Monitor flag bytes 6-21 are not cleared by a read here.
// R17: Monitor-pending clears and interrupt asserts within 2000 ms of power-up.
// R18: Mask set or cleared takes effect on the interrupt within 100 ms. Only bits 0-3 of bytes 100 and 101 gate it here.
module lmap_lower_page
   import lmap_pkg::*;
#(
   parameter logic [7:0] IDENT_CODE        = 8'h5a,
   parameter logic [6:0] BUS_ADDR          = 7'h50,
   parameter int         MON_READY_CYCLES  = LMAP_MON_READY_CYCLES,
   parameter int         CHANNELS          = LMAP_CHANNELS
) (
   // Clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          rst_in,
   // 2-wire serial bus
   input  wire logic                          scl_in,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe_out,
   // Interrupt pin
   output logic                               interrupt_out_n,
   // Channel conditions
   input  wire logic [CHANNELS-1:0]           rx_signal_loss_ch_in,
   input  wire logic [CHANNELS-1:0]           tx_fault_ch_in,
   // Monitor side
   input  wire logic                          monitor_valid_in,
   input  wire logic [LMAP_MON_BYTES*8-1:0]   monitor_values_in,
   input  wire logic [LMAP_MFLG_BYTES*8-1:0]  monitor_flags_in,
   // Control state toward the module
   output logic [LMAP_CTRL_BYTES*8-1:0]       control_bytes_out,
   output logic [7:0]                         page_select_out
);
   // Identifier value is arbitrary, not tied to any real code
   localparam int TW = $clog2(MON_READY_CYCLES + 1);

   lmap_acc_if acc ();

   logic [7:0]          ctrl_q [LMAP_CTRL_BYTES];
   logic [7:0]          mask_q [LMAP_MASK_BYTES];
   logic [7:0]          upper_mem [LMAP_UPPER_DEPTH];
   logic [7:0]          page_q;
   logic                dnr_q;
   logic [TW-1:0]       mon_timer_q;
   logic                ready_evt_q;
   logic                int_n_q;
   logic                sda_out_q;
   logic [CHANNELS-1:0] rx_flags;
   logic [CHANNELS-1:0] tx_flags;
   logic                dnr_clear;
   logic                int_req;
   logic [7:0]          status_w;
   logic [7:0]          rdata_w;
   logic [3:0]          ctrl_idx;
   logic [2:0]          mask_idx;
   logic [5:0]          mon_idx;
   logic [3:0]          mflg_idx;
   logic                upper_rw_page;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   lmap_serial_slave #(
      .BUS_ADDR (BUS_ADDR)
   ) u_serial (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_oe_out  (sda_oe_out),
      .acc         (acc.serial)
   );

   // R12 receive loss latches, cleared by reading byte 3
   lmap_flag_latch #(
      .WIDTH (CHANNELS)
   ) u_rx_loss (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .cond_in     (rx_signal_loss_ch_in),
      .clr_in      (acc.rd_stb && (acc.addr == LMAP_ADDR_RX_LOSS)),
      .clr_bits_in (acc.rd_val[CHANNELS-1:0]),
      .flags_out   (rx_flags)
   );

   // R13 transmit fault latches, cleared by reading byte 4
   lmap_flag_latch #(
      .WIDTH (CHANNELS)
   ) u_tx_fault (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .cond_in     (tx_fault_ch_in),
      .clr_in      (acc.rd_stb && (acc.addr == LMAP_ADDR_TX_FAULT)),
      .clr_bits_in (acc.rd_val[CHANNELS-1:0]),
      .flags_out   (tx_flags)
   );

   assign ctrl_idx      = 4'(acc.addr - LMAP_CTRL_FIRST);
   assign mask_idx      = 3'(acc.addr - LMAP_MASK_FIRST);
   assign mon_idx       = 6'(acc.addr - LMAP_MON_FIRST);
   assign mflg_idx      = 4'(acc.addr - LMAP_MON_FLAG_FIRST);
   assign upper_rw_page = (page_q == LMAP_PAGE_02) || (page_q == LMAP_PAGE_03);

   // R5 control bytes take host writes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < LMAP_CTRL_BYTES; i++) begin
            ctrl_q[i] <= '0;
         end
      end else if (acc.wr_stb && in_range(acc.addr, LMAP_CTRL_FIRST, LMAP_CTRL_LAST)) begin
         ctrl_q[ctrl_idx] <= acc.wdata;
      end
   end

   // R5 mask bytes take host writes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < LMAP_MASK_BYTES; i++) begin
            mask_q[i] <= '0;
         end
      end else if (acc.wr_stb && in_range(acc.addr, LMAP_MASK_FIRST, LMAP_MASK_LAST)) begin
         mask_q[mask_idx] <= acc.wdata;
      end
   end

   // R2 page select register
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         page_q <= LMAP_PAGE_00;
      end else if (acc.wr_stb && (acc.addr == LMAP_ADDR_PAGE_SEL)) begin
         page_q <= acc.wdata;
      end
   end

   // R3 pages 02 and 03 share one array; page bit 0 picks the half
   always_ff @(posedge core_clk_in) begin
      if (acc.wr_stb && acc.addr[7] && upper_rw_page) begin
         upper_mem[{page_q[0], acc.addr[6:0]}] <= acc.wdata;
      end
   end

   // R17 timer bounds the wait for monitor data
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mon_timer_q <= '0;
      end else if (dnr_q && !dnr_clear) begin
         mon_timer_q <= mon_timer_q + 1'b1;
      end
   end

   assign dnr_clear = dnr_q && (monitor_valid_in || (mon_timer_q == TW'(MON_READY_CYCLES - 1)));

   // R9 pending from power-up; R10 nothing but reset sets it again
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         dnr_q <= 1'b1;
      end else if (dnr_clear) begin
         dnr_q <= 1'b0;
      end
   end

   // R17 data-ready event drives the interrupt until status is read
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ready_evt_q <= 1'b0;
      end else if (dnr_clear) begin
         ready_evt_q <= 1'b1;
      end else if (acc.rd_stb && (acc.addr == LMAP_ADDR_STATUS)) begin
         ready_evt_q <= 1'b0;
      end
   end

   // R18 masks gate the channel flags combinationally, so they act within cycles
   assign int_req = |(rx_flags & ~mask_q[3'(LMAP_MASK_RX_LOSS - LMAP_MASK_FIRST)][CHANNELS-1:0])
                  | |(tx_flags & ~mask_q[3'(LMAP_MASK_TX_FAULT - LMAP_MASK_FIRST)][CHANNELS-1:0])
                  | |monitor_flags_in
                  | ready_evt_q;

   // R15 pin asserts a cycle after a flag sets; R16 releases after clear
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         int_n_q <= 1'b1;
      end else begin
         int_n_q <= ~int_req;
      end
   end

   // SDA is open drain: only ever pulled low
   always_ff @(posedge core_clk_in) begin
      sda_out_q <= 1'b0;
   end

   // R7 paged; R8 pin mirror; R9 pending bit; R14 rest zero
   always_comb begin
      status_w                    = '0;
      status_w[LMAP_ST_PAGED_BIT] = 1'b1;
      status_w[LMAP_ST_INTN_BIT]  = int_n_q;
      status_w[LMAP_ST_DNR_BIT]   = dnr_q;
   end

   // R1 lower page decodes regardless of page select
   always_comb begin
      rdata_w = '0;
      if (acc.addr[7]) begin
         // R4 identifier repeated at upper page 00 byte 128
         if ((page_q == LMAP_PAGE_00) && (acc.addr == LMAP_UPPER_IDENT)) begin
            rdata_w = IDENT_CODE;
         end else if (upper_rw_page) begin
            rdata_w = upper_mem[{page_q[0], acc.addr[6:0]}];
         end
      end else if (acc.addr == LMAP_ADDR_IDENT) begin
         // R4 identifier byte
         rdata_w = IDENT_CODE;
      end else if (acc.addr == LMAP_ADDR_STATUS) begin
         rdata_w = status_w;
      end else if (acc.addr == LMAP_ADDR_RX_LOSS) begin
         // R12 upper nibble reserved
         rdata_w[CHANNELS-1:0] = rx_flags;
      end else if (acc.addr == LMAP_ADDR_TX_FAULT) begin
         // R13 upper nibble reserved
         rdata_w[CHANNELS-1:0] = tx_flags;
      end else if (in_range(acc.addr, LMAP_MON_FLAG_FIRST, LMAP_MON_FLAG_LAST)) begin
         // R11 monitor flags as latched by the monitor logic
         rdata_w = monitor_flags_in[mflg_idx*8 +: 8];
      end else if (in_range(acc.addr, LMAP_MON_FIRST, LMAP_MON_LAST)) begin
         // R6 monitor values are read only
         rdata_w = monitor_values_in[mon_idx*8 +: 8];
      end else if (in_range(acc.addr, LMAP_CTRL_FIRST, LMAP_CTRL_LAST)) begin
         rdata_w = ctrl_q[ctrl_idx];
      end else if (in_range(acc.addr, LMAP_MASK_FIRST, LMAP_MASK_LAST)) begin
         rdata_w = mask_q[mask_idx];
      end else if (acc.addr == LMAP_ADDR_PAGE_SEL) begin
         rdata_w = page_q;
      end
   end

   assign acc.rdata = rdata_w;

   genvar g;
   generate
      for (g = 0; g < LMAP_CTRL_BYTES; g++) begin : g_ctrl_out
         assign control_bytes_out[g*8 +: 8] = ctrl_q[g];
      end
   endgenerate

   assign page_select_out = page_q;
   assign interrupt_out_n = int_n_q;
   assign sda_out         = sda_out_q;
endmodule : lmap_lower_page

/* inc/lmap_pkg.sv */
// Constants for the lower page of the module management map.
// Assumes one 40 MHz core clock.
package lmap_pkg;
   // Lower page layout
   localparam logic [7:0] LMAP_ADDR_IDENT     = 8'h00;
   localparam logic [7:0] LMAP_ADDR_STATUS    = 8'h02;
   localparam logic [7:0] LMAP_ADDR_RX_LOSS   = 8'h03;
   localparam logic [7:0] LMAP_ADDR_TX_FAULT  = 8'h04;
   localparam logic [7:0] LMAP_MON_FLAG_FIRST = 8'h06;
   localparam logic [7:0] LMAP_MON_FLAG_LAST  = 8'h15;
   localparam logic [7:0] LMAP_MON_FIRST      = 8'h16;
   localparam logic [7:0] LMAP_MON_LAST       = 8'h51;
   localparam logic [7:0] LMAP_CTRL_FIRST     = 8'h56;
   localparam logic [7:0] LMAP_CTRL_LAST      = 8'h61;
   localparam logic [7:0] LMAP_MASK_FIRST     = 8'h64;
   localparam logic [7:0] LMAP_MASK_LAST      = 8'h6a;
   localparam logic [7:0] LMAP_MASK_RX_LOSS   = 8'h64;
   localparam logic [7:0] LMAP_MASK_TX_FAULT  = 8'h65;
   localparam logic [7:0] LMAP_ADDR_PAGE_SEL  = 8'h7f;
   localparam logic [7:0] LMAP_UPPER_IDENT    = 8'h80;
   // Sizes
   localparam int LMAP_CHANNELS   = 4;
   localparam int LMAP_CTRL_BYTES = 12;
   localparam int LMAP_MASK_BYTES = 7;
   localparam int LMAP_MON_BYTES  = 60;
   localparam int LMAP_MFLG_BYTES = 16;
   localparam int LMAP_UPPER_DEPTH = 256;
   // Status byte fields
   localparam int LMAP_ST_PAGED_BIT = 2;
   localparam int LMAP_ST_INTN_BIT  = 1;
   localparam int LMAP_ST_DNR_BIT   = 0;
   // Upper page numbers
   localparam logic [7:0] LMAP_PAGE_00 = 8'h00;
   localparam logic [7:0] LMAP_PAGE_02 = 8'h02;
   localparam logic [7:0] LMAP_PAGE_03 = 8'h03;
   // Serial byte framing
   localparam logic [3:0] LMAP_BYTE_BITS = 4'h8;
   localparam logic [3:0] LMAP_LAST_BIT  = 4'h7;
   // Timing
   localparam int LMAP_CLK_KHZ          = 40_000;
   localparam int LMAP_T_MON_READY_MS   = 2000;
   localparam int LMAP_MON_READY_CYCLES = LMAP_T_MON_READY_MS * LMAP_CLK_KHZ;
   // Serial slave states
   typedef enum logic [2:0] {
      LMAP_SER_IDLE = 3'b000,
      LMAP_SER_DEV  = 3'b001,
      LMAP_SER_OFFS = 3'b010,
      LMAP_SER_WDAT = 3'b011,
      LMAP_SER_ACK  = 3'b100,
      LMAP_SER_RDAT = 3'b101,
      LMAP_SER_RACK = 3'b110
   } lmap_ser_state_e;
endpackage : lmap_pkg

/* inc/lmap_acc_if.sv */
// Byte access path between the serial slave and the lower page map.
// Assumes both ends run on the core clock; strobes are one cycle wide.
`timescale 1ns/1ps
interface lmap_acc_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rd_val;
   logic [7:0] rdata;
   modport serial (output addr, output wdata, output wr_stb, output rd_stb, output rd_val, input rdata);
   modport map    (input addr, input wdata, input wr_stb, input rd_stb, input rd_val, output rdata);
endinterface : lmap_acc_if

/* hw/lmap_flag_latch.sv */
// Latched condition flags, set on a rising condition and cleared by a read.
// Assumes condition inputs are asynchronous pins.
`timescale 1ns/1ps
module lmap_flag_latch
   import lmap_pkg::*;
#(
   parameter int WIDTH = LMAP_CHANNELS
) (
   // Clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   // Conditions and clearing
   input  wire logic [WIDTH-1:0] cond_in,
   input  wire logic             clr_in,
   input  wire logic [WIDTH-1:0] clr_bits_in,
   // Latched flags
   output logic      [WIDTH-1:0] flags_out
);
   logic [WIDTH-1:0] sync0_q;
   logic [WIDTH-1:0] sync1_q;
   logic [WIDTH-1:0] sync2_q;
   logic [WIDTH-1:0] filt_q;
   logic [WIDTH-1:0] filt_d;
   logic [WIDTH-1:0] flags_q;

   // A level counts only once the second and third stage agree
   assign filt_d = ((sync1_q ~^ sync2_q) & sync2_q) | ((sync1_q ^ sync2_q) & filt_q);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync0_q <= '0;
         sync1_q <= '0;
         sync2_q <= '0;
         filt_q  <= '0;
      end else begin
         sync0_q <= cond_in;
         sync1_q <= sync0_q;
         sync2_q <= sync1_q;
         filt_q  <= filt_d;
      end
   end

   // R16 clear only reported bits; R11 set wins
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~(clr_in ? clr_bits_in : '0)) | (filt_d & ~filt_q);
      end
   end

   assign flags_out = flags_q;
endmodule : lmap_flag_latch

/* hw/lmap_serial_slave.sv */
// 2-wire serial slave with an auto-incrementing byte pointer.
// Assumes open-drain SDA resolved outside; pins are asynchronous.
`timescale 1ns/1ps
module lmap_serial_slave
   import lmap_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = 7'h50
) (
   // Clock and reset
   input  wire logic  core_clk_in,
   input  wire logic  rst_in,
   // Serial pins
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   output logic       sda_oe_out,
   // Byte access toward the map
   lmap_acc_if.serial acc
);
   logic [2:0]      scl_s_q;
   logic [2:0]      sda_s_q;
   logic            scl_f_q;
   logic            sda_f_q;
   logic            scl_p_q;
   logic            sda_p_q;
   lmap_ser_state_e state_q;
   lmap_ser_state_e next_q;
   logic [3:0]      cnt_q;
   logic [7:0]      sh_q;
   logic [7:0]      rbyte_q;
   logic [7:0]      ptr_q;
   logic            oe_q;
   logic            acked_q;
   logic            wr_stb_q;
   logic            rd_stb_q;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_w;
   logic            stop_w;
   logic            byte_done;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
         if (scl_s_q[1] == scl_s_q[2]) begin
            scl_f_q <= scl_s_q[2];
         end
         if (sda_s_q[1] == sda_s_q[2]) begin
            sda_f_q <= sda_s_q[2];
         end
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   assign scl_rise  = scl_f_q & ~scl_p_q;
   assign scl_fall  = ~scl_f_q & scl_p_q;
   assign start_w   = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   assign stop_w    = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
   assign byte_done = scl_fall && (cnt_q == LMAP_BYTE_BITS);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_q <= LMAP_SER_IDLE;
         next_q  <= LMAP_SER_IDLE;
         cnt_q   <= '0;
         sh_q    <= '0;
         rbyte_q <= '0;
         oe_q    <= 1'b0;
         acked_q <= 1'b0;
      end else if (start_w) begin
         state_q <= LMAP_SER_DEV;
         cnt_q   <= '0;
         oe_q    <= 1'b0;
      end else if (stop_w) begin
         state_q <= LMAP_SER_IDLE;
         oe_q    <= 1'b0;
      end else begin
         case (state_q)
            LMAP_SER_DEV, LMAP_SER_OFFS, LMAP_SER_WDAT: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_f_q};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  oe_q    <= 1'b1;
                  state_q <= LMAP_SER_ACK;
                  if (state_q == LMAP_SER_DEV) begin
                     next_q <= sh_q[0] ? LMAP_SER_RDAT : LMAP_SER_OFFS;
                     if (sh_q[7:1] != BUS_ADDR) begin
                        // Not our address: stay silent until the next start
                        oe_q    <= 1'b0;
                        state_q <= LMAP_SER_IDLE;
                     end
                  end else begin
                     next_q <= LMAP_SER_WDAT;
                  end
               end
            end
            LMAP_SER_ACK: begin
               if (scl_fall) begin
                  cnt_q   <= '0;
                  state_q <= next_q;
                  oe_q    <= (next_q == LMAP_SER_RDAT) ? ~acc.rdata[7] : 1'b0;
                  sh_q    <= acc.rdata;
                  rbyte_q <= acc.rdata;
               end
            end
            LMAP_SER_RDAT: begin
               if (scl_fall) begin
                  cnt_q <= cnt_q + 4'h1;
                  sh_q  <= {sh_q[6:0], 1'b0};
                  oe_q  <= ~sh_q[6];
                  if (cnt_q == LMAP_LAST_BIT) begin
                     oe_q    <= 1'b0;
                     state_q <= LMAP_SER_RACK;
                  end
               end
            end
            LMAP_SER_RACK: begin
               if (scl_rise) begin
                  acked_q <= ~sda_f_q;
               end else if (scl_fall) begin
                  cnt_q   <= '0;
                  state_q <= acked_q ? LMAP_SER_RDAT : LMAP_SER_IDLE;
                  oe_q    <= acked_q & ~acc.rdata[7];
                  sh_q    <= acc.rdata;
                  rbyte_q <= acc.rdata;
               end
            end
            default: begin
               state_q <= LMAP_SER_IDLE;
               oe_q    <= 1'b0;
            end
         endcase
      end
   end

   // Strobes land one cycle after the byte so the pointer still names it
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= (state_q == LMAP_SER_WDAT) && byte_done && !start_w && !stop_w;
         rd_stb_q <= (state_q == LMAP_SER_RACK) && scl_rise && !start_w && !stop_w;
      end
   end

   // R2 pointer stays put across transactions
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ptr_q <= '0;
      end else if ((state_q == LMAP_SER_OFFS) && byte_done && !start_w && !stop_w) begin
         ptr_q <= sh_q;
      end else if (wr_stb_q || rd_stb_q) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   assign acc.addr   = ptr_q;
   assign acc.wdata  = sh_q;
   assign acc.wr_stb = wr_stb_q;
   assign acc.rd_stb = rd_stb_q;
   assign acc.rd_val = rbyte_q;
   assign sda_oe_out = oe_q;
endmodule : lmap_serial_slave

/* test/lmap_lower_page_properties.sv */
// Port checker for the lower page map, bound into the top module.
// Assumes a single core clock and synchronous reset.
`timescale 1ns/1ps
module lmap_lower_page_properties #(
   parameter int MON_READY_CYCLES = 50,
   parameter int CHANNELS         = 4
) (
   input wire logic                core_clk_in,
   input wire logic                rst_in,
   input wire logic                scl_in,
   input wire logic                sda_out,
   input wire logic                sda_oe_out,
   input wire logic                interrupt_out_n,
   input wire logic [CHANNELS-1:0] tx_fault_ch_in,
   input wire logic [127:0]        monitor_flags_in,
   input wire logic [95:0]         control_bytes_out,
   input wire logic [7:0]          page_select_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   int   cnt_q;
   logic seen_q;
   // Saturates so the timer check fires once per power-up
   always_ff @(posedge core_clk_in) begin
      if (rst_in) cnt_q <= 0;
      else if (cnt_q < MON_READY_CYCLES + 9) cnt_q <= cnt_q + 1;
   end
   always_ff @(posedge core_clk_in) begin
      seen_q <= !rst_in && (seen_q || !interrupt_out_n);
   end
   sequence s_int_soon;
      ##[1:12] !interrupt_out_n;
   endsequence
   chk_sda_low: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   chk_reset_idle: assert property ($fell(rst_in) |-> interrupt_out_n && page_select_out == 8'h00
      && control_bytes_out == '0) else $error("outputs not idle after reset");
   chk_tx_raise: assert property ($rose(|tx_fault_ch_in) |-> s_int_soon)
      else $error("no interrupt after transmit fault");
   chk_mon_raise: assert property ($rose(|monitor_flags_in) |-> s_int_soon)
      else $error("no interrupt after monitor flag");
   chk_write_scl_low: assert property (!$past(rst_in) && (!$stable(control_bytes_out)
      || !$stable(page_select_out)) |-> !scl_in) else $error("register write while clock high");
   chk_ack_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("data line pulled while clock high");
   chk_oe_hold: assert property (!$past(rst_in) && scl_in [*6] |-> $stable(sda_oe_out))
      else $error("data line changed while clock high");
   chk_ready_timer: assert property (cnt_q == MON_READY_CYCLES + 8 |-> seen_q)
      else $error("no interrupt after monitor ready time");
endmodule : lmap_lower_page_properties
bind lmap_lower_page lmap_lower_page_properties #(
   .MON_READY_CYCLES(MON_READY_CYCLES), .CHANNELS(CHANNELS)) u_props (.*);

/* test/lmap_host_model.sv */
// Host on the 2-wire bus: byte writes and offset reads.
// Assumes SDA is resolved outside with a pull-up.
`timescale 1ns/1ps
module lmap_host_model #(
   parameter logic [6:0] DEV = 7'h50
) (
   input  wire logic core_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   localparam int HALF = 12;
   initial {scl_out, sda_out} = 2'b11;
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : wait_clk
   // Data changes only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_out <= b;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      r = sda_in;
      scl_out <= 1'b0;
      wait_clk(2);
   endtask : bit_io
   task automatic start();
      sda_out <= 1'b1;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      sda_out <= 1'b0;
      wait_clk(HALF);
      scl_out <= 1'b0;
      wait_clk(HALF);
   endtask : start
   task automatic stop();
      sda_out <= 1'b0;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      sda_out <= 1'b1;
      wait_clk(HALF);
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, k);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       k0, k1, k2;
      start();
      xfer({DEV, 1'b0}, 1'b1, x, k0);
      xfer(a, 1'b1, x, k1);
      xfer(d, 1'b1, x, k2);
      stop();
      ok = !(k0 | k1 | k2);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
      logic [7:0] x;
      logic       k0, k1, k2, n;
      start();
      xfer({DEV, 1'b0}, 1'b1, x, k0);
      xfer(a, 1'b1, x, k1);
      start();
      xfer({DEV, 1'b1}, 1'b1, x, k2);
      xfer(8'hff, 1'b1, q, n);
      stop();
      ok = !(k0 | k1 | k2);
   endtask : rd
endmodule : lmap_host_model

/* test/lmap_lower_page_bench.sv */
// Self-checking bench for the lower page map.
// Assumes the host model is the only bus master.
`timescale 1ns/1ps
module lmap_lower_page_bench;
   localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         scl, h_sda, sda, oe, int_n, ok;
   logic [3:0]   rx = '0;
   logic [3:0]   tx = '0;
   logic [127:0] mflg = '0;
   logic [95:0]  ctrl;
   logic [7:0]   page, q;
   int           fail_count = 0;
   int           tests_run = 0;
   // Open drain with pull-up
   assign sda = h_sda & ~oe;
   lmap_lower_page #(.IDENT_CODE(IDENT), .MON_READY_CYCLES(8000)) u_dut (
      .core_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(oe),
      .interrupt_out_n(int_n), .rx_signal_loss_ch_in(rx), .tx_fault_ch_in(tx), .monitor_valid_in(1'b0),
      .monitor_values_in('0), .monitor_flags_in(mflg), .control_bytes_out(ctrl), .page_select_out(page));
   lmap_host_model u_host (.core_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(h_sda));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, q, ok);
      cmp("ack", 8'h01, {7'h0, ok});
      cmp($sformatf("byte %0d", a), e, q);
   endtask : rdc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.wr(a, d, ok);
      cmp("ack", 8'h01, {7'h0, ok});
   endtask : wr
   // 20000 cycles is the 500 us release limit
   task automatic wait_int(input logic lvl);
      for (int n = 0; int_n !== lvl && n < 20000; n++) @(negedge clk);
      cmp("int_n", {7'h0, lvl}, {7'h0, int_n});
   endtask : wait_int
   task automatic t_status();
      rdc(8'h00, IDENT);
      rdc(8'h02, 8'h07);
      rdc(8'h01, 8'h00);
      rdc(8'h05, 8'h00);
      wait_int(1'b0);
      rdc(8'h02, 8'h04);
      wait_int(1'b1);
      rdc(8'h02, 8'h06);
   endtask : t_status
   task automatic t_map();
      wr(8'h00, 8'hff);
      rdc(8'h00, IDENT);
      wr(8'h56, 8'ha5);
      cmp("ctrl", 8'ha5, ctrl[7:0]);
      wr(8'h62, 8'h11);
      rdc(8'h62, 8'h00);
      wr(8'h7f, 8'h02);
      cmp("page", 8'h02, page);
      wr(8'h80, 8'h3a);
      rdc(8'h80, 8'h3a);
      rdc(8'h00, IDENT);
      wr(8'h7f, 8'h01);
      rdc(8'h80, 8'h00);
      wr(8'h7f, 8'h00);
      rdc(8'h80, IDENT);
   endtask : t_map
   task automatic t_flags();
      @(posedge clk);
      tx <= 4'b0100;
      wait_int(1'b0);
      rdc(8'h04, 8'h04);
      wait_int(1'b1);
      rdc(8'h04, 8'h00);
      @(posedge clk);
      rx <= 4'b0001;
      wait_int(1'b0);
      rdc(8'h03, 8'h01);
      wait_int(1'b1);
      wr(8'h64, 8'h0f);
      @(posedge clk);
      rx <= 4'b0011;
      repeat (200) @(negedge clk);
      cmp("masked int_n", 8'h01, {7'h0, int_n});
      rdc(8'h03, 8'h02);
      @(posedge clk);
      mflg <= 128'h80;
      wait_int(1'b0);
      rdc(8'h06, 8'h80);
   endtask : t_flags
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_status();
      t_map();
      t_flags();
      wrap_up();
   end
   // Tests need about 28000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule : lmap_lower_page_bench
